// file: mch_channel_handler.v
// MIDI channel message handler: receive decoder, mode messages, active
// sensing supervision and transmit sequencer, with an APB register slave.
// Assumes byte-level UART on clk outside; pedal pin is asynchronous.
//
// Summary of operation
// R01: Program change selects patch for channel's part
// R02: Channel pressure is DnH plus one data byte
// R03: Pitch bend: low then high, signed 14-bit
// R04: Controller 120 zero silences channel notes now
// R05: Controller 121 resets controllers to defaults
// R06: Controller 123 releases notes, hold delays release
// R07: Controllers 124/125 act as notes off only
// R08: Controller 126 notes off, then mono on
// R09: Controller 127 notes off, then mono off
// R10: Sensing gap over 420 ms resets all channels
// R11: Sent notes 21..116, velocities clamped to range
// R12: Slider sends control change with chosen number
// R13: Pedal sends controller 64 only when damper
// R14: Active sensing sent about every 250 ms
// R15: No sensing sent while send enable off
// R16: Hold controller: below 64 off, else on
// R17: Top bit set means status byte
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "mch_consts.vh"

module mch_channel_handler #(
   parameter SENSE_TO_CYCLES = `MCH_SENSE_TO_MS * `MCH_CLK_KHZ,
   parameter SENSE_TX_CYCLES = `MCH_SENSE_TX_MS * `MCH_CLK_KHZ
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg irq,
   // Received bytes from UART
   input wire [7:0] rxData,
   input wire rxValid,
   // Transmit bytes to UART
   output reg [7:0] txData,
   output reg txValid,
   input wire txReady,
   // Panel inputs
   input wire pedalPin,
   input wire [6:0] sliderPos,
   input wire sliderStrobe,
   // Sound engine events
   output reg [3:0] evtChannel,
   output reg evtAllChannels,
   output reg evtPatch,
   output reg [6:0] patchNum,
   output reg evtSoundOff,
   output reg evtNotesOff,
   output reg evtHoldActive,
   output reg evtCtrlReset,
   output reg [15:0] monoMode,
   output reg [15:0] holdOn
);

   localparam TX_IDLE = 2'b01;
   localparam TX_SEND = 2'b10;

   function [6:0] clampRange;
      input [6:0] v, lo, hi;
      if (v < lo)
         clampRange = lo;
      else if (v > hi)
         clampRange = hi;
      else
         clampRange = v;
   endfunction

   function hitReg;
      input [7:0] a, off;
      hitReg = (a == off);
   endfunction

   // Registers
   reg [31:0] ctrl;
   reg [`MCH_INT_W-1:0] intStat;
   reg [`MCH_INT_W-1:0] intEn;
   reg [3:0] chSel;
   reg [6:0] sliderCc;
   reg [22:0] txCmd;
   reg txCmdPend;

   // Receive parser state
   reg [3:0] runStatus;
   reg [3:0] runChan;
   reg statusOk;
   reg haveFirst;
   reg [6:0] firstData;
   reg [6:0] chanPress [0:15];
   reg [6:0] modDepth [0:15];
   reg [6:0] exprLevel [0:15];
   reg [13:0] bendRaw [0:15];
   reg [`MCH_INT_W-1:0] intSet;
   integer i;

   // Active sensing supervision
   reg senseArmed;
   reg [31:0] gapCount;

   // Transmit
   reg [1:0] txState;
   reg [7:0] txBuf0, txBuf1, txBuf2;
   reg [1:0] txLen;
   reg [1:0] txIdx;
   reg [31:0] senseTxCount;
   reg sensePend, pedalPend, sliderPend;
   reg [6:0] sliderVal;
   reg pedalMeta, pedalSync, pedalLast;

   wire apbSetup = psel & ~penable;
   wire apbWrite = psel & penable & pready & pwrite;
   wire [3:0] txChan = ctrl[`MCH_CTRL_CH_HI:`MCH_CTRL_CH_LO];
   wire isStatus = rxData[7]; // R17
   wire [6:0] rxVal = rxData[6:0];

   // APB: one wait-free access; data and error are registered in setup
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= apbSetup;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         if (apbSetup) begin
            case (paddr)
               `MCH_REG_CTRL: prdata <= ctrl;
               `MCH_REG_INTSTAT: prdata <= {{(32-`MCH_INT_W){1'b0}}, intStat};
               `MCH_REG_INTCLR: ;
               `MCH_REG_INTEN: prdata <= {{(32-`MCH_INT_W){1'b0}}, intEn};
               `MCH_REG_PATCH: prdata <= {20'h0, evtChannel, 1'b0, patchNum};
               `MCH_REG_MODE: prdata <= {holdOn, monoMode};
               `MCH_REG_CHSEL: prdata <= {28'h0, chSel};
               `MCH_REG_CHSTATE: prdata <= {11'h0, exprLevel[chSel], modDepth[chSel], chanPress[chSel]};
               `MCH_REG_CHBEND: prdata <= {18'h0, bendRaw[chSel]};
               `MCH_REG_TXCMD: prdata <= {9'h0, txCmd};
               `MCH_REG_TXSTAT: prdata <= {30'h0, txState == TX_SEND, txCmdPend};
               `MCH_REG_SLIDERCC: prdata <= {25'h0, sliderCc};
               `MCH_REG_SENSE: prdata <= {31'h0, senseArmed};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Software registers and interrupt logic; hardware set beats clear
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `MCH_CTRL_RESET;
         intStat <= {`MCH_INT_W{1'b0}};
         intEn <= {`MCH_INT_W{1'b0}};
         chSel <= 4'h0;
         sliderCc <= `MCH_SLIDER_RESET;
         irq <= 1'b0;
      end else begin
         if (apbWrite && hitReg(paddr, `MCH_REG_CTRL))
            ctrl <= pwdata;
         if (apbWrite && hitReg(paddr, `MCH_REG_INTEN))
            intEn <= pwdata[`MCH_INT_W-1:0];
         if (apbWrite && hitReg(paddr, `MCH_REG_CHSEL))
            chSel <= pwdata[3:0];
         if (apbWrite && hitReg(paddr, `MCH_REG_SLIDERCC))
            sliderCc <= pwdata[6:0]; // R12
         if (apbWrite && hitReg(paddr, `MCH_REG_INTCLR))
            intStat <= (intStat & ~pwdata[`MCH_INT_W-1:0]) | intSet;
         else
            intStat <= intStat | intSet;
         irq <= |(intStat & intEn);
      end
   end

   // Receive decoder and channel state
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         runStatus <= 4'h0;
         runChan <= 4'h0;
         statusOk <= 1'b0;
         haveFirst <= 1'b0;
         firstData <= 7'h00;
         evtChannel <= 4'h0;
         evtAllChannels <= 1'b0;
         evtPatch <= 1'b0;
         patchNum <= 7'h00;
         evtSoundOff <= 1'b0;
         evtNotesOff <= 1'b0;
         evtHoldActive <= 1'b0;
         evtCtrlReset <= 1'b0;
         monoMode <= 16'h0000;
         holdOn <= 16'h0000;
         intSet <= {`MCH_INT_W{1'b0}};
         senseArmed <= 1'b0;
         gapCount <= 32'h0;
         for (i = 0; i < 16; i = i + 1) begin
            chanPress[i] <= 7'h00;
            modDepth[i] <= 7'h00;
            exprLevel[i] <= `MCH_EXPR_MAX;
            bendRaw[i] <= `MCH_BEND_CENTRE;
         end
      end else begin
         evtPatch <= 1'b0;
         evtSoundOff <= 1'b0;
         evtNotesOff <= 1'b0;
         evtCtrlReset <= 1'b0;
         evtAllChannels <= 1'b0;
         intSet <= {`MCH_INT_W{1'b0}};
         // Gap timer restarts on every received byte once armed
         if (rxValid)
            gapCount <= 32'h0000_0000;
         else if (senseArmed)
            gapCount <= gapCount + 32'h1;
         if (senseArmed && !rxValid && gapCount >= SENSE_TO_CYCLES) begin
            senseArmed <= 1'b0; // R10
            evtAllChannels <= 1'b1;
            evtSoundOff <= 1'b1;
            evtNotesOff <= 1'b1;
            evtCtrlReset <= 1'b1;
            evtHoldActive <= 1'b0;
            holdOn <= 16'h0000;
            intSet[`MCH_INT_TIMEOUT] <= 1'b1;
            for (i = 0; i < 16; i = i + 1) begin
               chanPress[i] <= 7'h00;
               modDepth[i] <= 7'h00;
               exprLevel[i] <= `MCH_EXPR_MAX;
               bendRaw[i] <= `MCH_BEND_CENTRE;
            end
         end
         if (rxValid) begin
            if (rxData >= `MCH_BYTE_RTMIN) begin
               // Realtime bytes leave running status intact
               if (rxData == `MCH_BYTE_SENSE)
                  senseArmed <= 1'b1; // R10
            end else if (isStatus) begin
               runStatus <= rxData[7:4]; // R17
               runChan <= rxData[3:0];
               statusOk <= (rxData[7:4] != 4'hF);
               haveFirst <= 1'b0;
            end else if (statusOk) begin
               if (!haveFirst && runStatus != `MCH_ST_PROG && runStatus != `MCH_ST_CHPRESS) begin
                  firstData <= rxVal;
                  haveFirst <= 1'b1;
               end else begin
                  haveFirst <= 1'b0;
                  evtChannel <= runChan;
                  case (runStatus)
                     `MCH_ST_PROG: begin
                        patchNum <= rxVal; // R01
                        evtPatch <= 1'b1;
                        intSet[`MCH_INT_PATCH] <= 1'b1;
                     end
                     `MCH_ST_CHPRESS: begin
                        chanPress[runChan] <= rxVal; // R02
                        intSet[`MCH_INT_PRESS] <= 1'b1;
                     end
                     `MCH_ST_BEND: begin
                        bendRaw[runChan] <= {rxVal, firstData}; // R03
                        intSet[`MCH_INT_BEND] <= 1'b1;
                     end
                     `MCH_ST_CTRL: begin
                        case (firstData)
                           `MCH_CC_MOD: modDepth[runChan] <= rxVal;
                           `MCH_CC_EXPR: exprLevel[runChan] <= rxVal;
                           `MCH_CC_HOLD: holdOn[runChan] <= rxVal[6]; // R16
                           `MCH_CC_SOUNDOFF: begin
                              if (rxVal == 7'h00) begin
                                 evtSoundOff <= 1'b1; // R04
                                 intSet[`MCH_INT_MODE] <= 1'b1;
                              end
                           end
                           `MCH_CC_RESETALL: begin
                              if (rxVal == 7'h00) begin
                                 evtCtrlReset <= 1'b1; // R05
                                 chanPress[runChan] <= 7'h00;
                                 modDepth[runChan] <= 7'h00;
                                 exprLevel[runChan] <= `MCH_EXPR_MAX;
                                 bendRaw[runChan] <= `MCH_BEND_CENTRE;
                                 holdOn[runChan] <= 1'b0;
                                 intSet[`MCH_INT_MODE] <= 1'b1;
                              end
                           end
                           `MCH_CC_NOTESOFF, `MCH_CC_OMNIOFF, `MCH_CC_OMNION: begin
                              // Omni on is accepted but never enables omni reception
                              if (rxVal == 7'h00) begin
                                 evtNotesOff <= 1'b1; // R06 R07
                                 evtHoldActive <= holdOn[runChan]; // R06
                                 intSet[`MCH_INT_MODE] <= 1'b1;
                              end
                           end
                           `MCH_CC_MONO: begin
                              if (rxVal <= `MCH_MONO_MAX) begin
                                 evtNotesOff <= 1'b1; // R08
                                 evtHoldActive <= holdOn[runChan];
                                 monoMode[runChan] <= 1'b1; // R08
                                 intSet[`MCH_INT_MODE] <= 1'b1;
                              end
                           end
                           `MCH_CC_POLY: begin
                              if (rxVal == 7'h00) begin
                                 evtNotesOff <= 1'b1; // R09
                                 evtHoldActive <= holdOn[runChan];
                                 monoMode[runChan] <= 1'b0; // R09
                                 intSet[`MCH_INT_MODE] <= 1'b1;
                              end
                           end
                           default: ;
                        endcase
                     end
                     default: ;
                  endcase
               end
            end
         end
      end
   end

   // Pedal pin synchroniser and previous-level register
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pedalMeta <= 1'b0;
         pedalSync <= 1'b0;
         pedalLast <= 1'b0;
      end else begin
         pedalMeta <= pedalPin;
         pedalSync <= pedalMeta;
         pedalLast <= pedalSync;
      end
   end

   // Transmit sequencer; software command first, sensing last
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txState <= TX_IDLE;
         txData <= 8'h00;
         txValid <= 1'b0;
         txBuf0 <= 8'h00;
         txBuf1 <= 8'h00;
         txBuf2 <= 8'h00;
         txLen <= 2'd0;
         txIdx <= 2'd0;
         txCmd <= 23'h000000;
         txCmdPend <= 1'b0;
         senseTxCount <= 32'h0;
         sensePend <= 1'b0;
         pedalPend <= 1'b0;
         sliderPend <= 1'b0;
         sliderVal <= 7'h00;
      end else begin
         if (apbWrite && hitReg(paddr, `MCH_REG_TXCMD) && !txCmdPend) begin
            txCmd <= pwdata[22:0];
            txCmdPend <= 1'b1;
         end
         if (sliderStrobe) begin
            sliderPend <= 1'b1; // R12
            sliderVal <= sliderPos;
         end
         if (pedalSync != pedalLast && ctrl[`MCH_CTRL_DAMPER])
            pedalPend <= 1'b1; // R13
         if (!ctrl[`MCH_CTRL_TXSENSE]) begin
            senseTxCount <= 32'h0000_0000; // R15
            sensePend <= 1'b0;
         end else if (senseTxCount >= SENSE_TX_CYCLES - 1) begin
            senseTxCount <= 32'h0000_0000;
            sensePend <= 1'b1; // R14
         end else begin
            senseTxCount <= senseTxCount + 32'h1;
         end
         case (txState)
            TX_IDLE: begin
               txIdx <= 2'd0;
               if (txCmdPend) begin
                  txCmdPend <= 1'b0;
                  txState <= TX_SEND;
                  txBuf1 <= {1'b0, clampRange(txCmd[14:8], `MCH_NOTE_MIN, `MCH_NOTE_MAX)}; // R11
                  txBuf2 <= {1'b0, txCmd[22:16]};
                  txLen <= 2'd3;
                  case (txCmd[6:4])
                     `MCH_TX_NOTEOFF: txBuf0 <= {`MCH_ST_NOTEOFF, txCmd[3:0]};
                     `MCH_TX_NOTEON: begin
                        txBuf0 <= {`MCH_ST_NOTEON, txCmd[3:0]};
                        txBuf2 <= {1'b0, clampRange(txCmd[22:16], `MCH_VEL_MIN, `MCH_DATA_MAX)}; // R11
                     end
                     `MCH_TX_POLYKEY: txBuf0 <= {`MCH_ST_POLYKEY, txCmd[3:0]};
                     default: begin
                        txBuf0 <= {`MCH_ST_CHPRESS, txCmd[3:0]}; // R02
                        txBuf1 <= {1'b0, txCmd[14:8]};
                        txLen <= 2'd2;
                     end
                  endcase
               end else if (pedalPend) begin
                  pedalPend <= 1'b0;
                  txState <= TX_SEND;
                  txBuf0 <= {`MCH_ST_CTRL, txChan};
                  txBuf1 <= {1'b0, `MCH_CC_HOLD}; // R13
                  txBuf2 <= pedalSync ? {1'b0, `MCH_DATA_MAX} : 8'h00;
                  txLen <= 2'd3;
               end else if (sliderPend) begin
                  sliderPend <= 1'b0;
                  txState <= TX_SEND;
                  txBuf0 <= {`MCH_ST_CTRL, txChan};
                  txBuf1 <= {1'b0, sliderCc}; // R12
                  txBuf2 <= {1'b0, sliderVal};
                  txLen <= 2'd3;
               end else if (sensePend && ctrl[`MCH_CTRL_TXSENSE]) begin
                  sensePend <= 1'b0;
                  txState <= TX_SEND;
                  txBuf0 <= `MCH_BYTE_SENSE; // R14
                  txLen <= 2'd1;
               end
            end
            TX_SEND: begin
               if (!txValid) begin
                  txValid <= 1'b1;
                  txData <= (txIdx == 2'd0) ? txBuf0 : (txIdx == 2'd1) ? txBuf1 : txBuf2;
               end else if (txReady) begin
                  txValid <= 1'b0;
                  txIdx <= txIdx + 2'd1;
                  if (txIdx + 2'd1 == txLen)
                     txState <= TX_IDLE;
               end
            end
            default: txState <= TX_IDLE;
         endcase
      end
   end

endmodule

// file: mch_consts.vh
// Constants for the channel message handler: APB map, MIDI codes, timing.
// Definitions only. Included by mch_channel_handler.v.
`ifndef MCH_CONSTS_VH
`define MCH_CONSTS_VH

// APB register byte offsets
`define MCH_REG_CTRL     8'h00
`define MCH_REG_INTSTAT  8'h04
`define MCH_REG_INTCLR   8'h08
`define MCH_REG_INTEN    8'h0C
`define MCH_REG_PATCH    8'h10
`define MCH_REG_MODE     8'h14
`define MCH_REG_CHSEL    8'h18
`define MCH_REG_CHSTATE  8'h1C
`define MCH_REG_CHBEND   8'h20
`define MCH_REG_TXCMD    8'h24
`define MCH_REG_TXSTAT   8'h28
`define MCH_REG_SLIDERCC 8'h2C
`define MCH_REG_SENSE    8'h30

// Control register fields and reset value
`define MCH_CTRL_TXSENSE 0
`define MCH_CTRL_DAMPER  1
`define MCH_CTRL_CH_LO   4
`define MCH_CTRL_CH_HI   7
`define MCH_CTRL_RESET   32'h0000_0001
`define MCH_SLIDER_RESET 7'h07

// Interrupt status bits
`define MCH_INT_PATCH    0
`define MCH_INT_PRESS    1
`define MCH_INT_BEND     2
`define MCH_INT_MODE     3
`define MCH_INT_TIMEOUT  4
`define MCH_INT_W        5

// MIDI status nibbles and bytes
`define MCH_ST_NOTEOFF   4'h8
`define MCH_ST_NOTEON    4'h9
`define MCH_ST_POLYKEY   4'hA
`define MCH_ST_CTRL      4'hB
`define MCH_ST_PROG      4'hC
`define MCH_ST_CHPRESS   4'hD
`define MCH_ST_BEND      4'hE
`define MCH_BYTE_SENSE   8'hFE
`define MCH_BYTE_RTMIN   8'hF8

// Controller numbers
`define MCH_CC_MOD       7'h01
`define MCH_CC_EXPR      7'h0B
`define MCH_CC_HOLD      7'h40
`define MCH_CC_SOUNDOFF  7'h78
`define MCH_CC_RESETALL  7'h79
`define MCH_CC_NOTESOFF  7'h7B
`define MCH_CC_OMNIOFF   7'h7C
`define MCH_CC_OMNION    7'h7D
`define MCH_CC_MONO      7'h7E
`define MCH_CC_POLY      7'h7F
`define MCH_MONO_MAX     7'h10

// Reset values of controllers
`define MCH_EXPR_MAX     7'h7F
`define MCH_BEND_CENTRE  14'h2000
`define MCH_DATA_MAX     7'h7F

// Transmit limits
`define MCH_NOTE_MIN     7'h15
`define MCH_NOTE_MAX     7'h74
`define MCH_VEL_MIN      7'h01

// Transmit command kinds
`define MCH_TX_NOTEOFF   3'h0
`define MCH_TX_NOTEON    3'h1
`define MCH_TX_POLYKEY   3'h2
`define MCH_TX_CHPRESS   3'h3

// Timing
`define MCH_CLK_KHZ      50000
`define MCH_SENSE_TO_MS  420
`define MCH_SENSE_TX_MS  250

`endif

// file: mch_asserts.sv
// Checker on the handler's receive, event and APB answer ports.
// Bound to the handler; sees only its ports.
`timescale 1ns/100ps
module mch_asserts (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Watched ports
   input wire [7:0] rxData,
   input wire rxValid,
   input wire [3:0] evtChannel,
   input wire evtAllChannels,
   input wire evtPatch,
   input wire [6:0] patchNum,
   input wire evtSoundOff,
   input wire evtNotesOff,
   input wire evtHoldActive,
   input wire evtCtrlReset,
   input wire [15:0] monoMode,
   input wire [15:0] holdOn,
   input wire pready,
   input wire pslverr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   reg [7:0] st;
   // Realtime bytes leave the running status alone
   always @(posedge clk or negedge rst_n)
      if (!rst_n) st <= 8'h00;
      else if (rxValid && rxData[7] && rxData < 8'hF8) st <= rxData;
   sequence s_cc(logic [7:0] n, logic [7:0] d);
      rxValid && rxData[7:4] == 4'hB ##1 rxValid && rxData == n ##1 rxValid && rxData == d;
   endsequence
   property p_prog;
      rxValid && rxData[7:4] == 4'hC ##1 rxValid && !rxData[7]
         |=> evtPatch && patchNum == $past(rxData[6:0]) && evtChannel == st[3:0];
   endproperty
   a_prog: assert property (p_prog) else $error("program change not decoded");
   property p_soff;
      s_cc(8'h78, 8'h00) |=> evtSoundOff && evtChannel == st[3:0];
   endproperty
   a_soff: assert property (p_soff) else $error("sound off missing");
   property p_noff;
      s_cc(8'h7B, 8'h00) |=> evtNotesOff && evtHoldActive == holdOn[st[3:0]];
   endproperty
   a_noff: assert property (p_noff) else $error("notes off missing");
   property p_omni;
      s_cc(8'h7D, 8'h00) |=> evtNotesOff && evtChannel == st[3:0];
   endproperty
   a_omni: assert property (p_omni) else $error("omni on not as notes off");
   property p_mono;
      s_cc(8'h7E, 8'h10) |-> ##[1:2] monoMode[st[3:0]];
   endproperty
   a_mono: assert property (p_mono) else $error("mono not set");
   property p_poly;
      s_cc(8'h7F, 8'h00) |-> ##[1:2] !monoMode[st[3:0]];
   endproperty
   a_poly: assert property (p_poly) else $error("mono not cleared");
   property p_hold;
      s_cc(8'h40, 8'h40) |-> ##[1:2] holdOn[st[3:0]];
   endproperty
   a_hold: assert property (p_hold) else $error("hold at 64 not on");
   property p_sto;
      evtAllChannels |-> evtSoundOff && evtNotesOff && evtCtrlReset;
   endproperty
   a_sto: assert property (p_sto) else $error("timeout reset incomplete");
   c_prog: cover property (evtPatch);
   c_to: cover property (evtAllChannels);
   c_err: cover property (pready && pslverr);
endmodule
bind mch_channel_handler mch_asserts mch_asserts_i (.*);

// file: mch_midi_peer.sv
// Far-side instrument: feeds bytes to the handler and takes its output.
// Assumes UART framing is done; bytes move on the handler's clock.
`timescale 1ns/100ps
module mch_midi_peer (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Bytes toward the handler
   output logic [7:0] rxData,
   output logic rxValid,
   // Bytes from the handler
   input wire [7:0] txData,
   input wire txValid,
   output logic txReady,
   // Slow acceptance
   input wire stall
);
   logic [7:0] got[$];
   initial begin
      rxData = 8'h00;
      rxValid = 1'b0;
   end
   // Slow mode refuses every other cycle
   always @(posedge clk or negedge rst_n)
      if (!rst_n) txReady <= 1'b0;
      else txReady <= stall ? !txReady : 1'b1;
   always @(posedge clk)
      if (rst_n && txValid && txReady) got.push_back(txData);
   // Status byte first, then data bytes below 80H
   task send(input logic [7:0] m[$]);
      foreach (m[k]) begin
         @(posedge clk);
         rxData <= m[k];
         rxValid <= 1'b1;
      end
      @(posedge clk);
      rxValid <= 1'b0;
      // An idle line must not show the stale byte
      rxData <= ~m[m.size() - 1];
      repeat (2) @(posedge clk);
   endtask
endmodule

// file: mch_channel_handler_test.sv
// Testbench for the channel handler: APB master, panel inputs, MIDI peer.
// Sensing counts are shortened by parameter.
`timescale 1ns/100ps
`include "mch_consts.vh"
module mch_channel_handler_test;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pedalPin = 1'b0;
   logic sliderStrobe = 1'b0, stall = 1'b0, se;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd;
   logic [6:0] sliderPos = 7'h00;
   wire [31:0] prdata;
   wire [7:0] rxData, txData;
   wire [15:0] monoMode, holdOn;
   wire pready, pslverr, irq, rxValid, txValid, txReady, evtAllChannels, evtHoldActive;
   int nMismatch = 0, totalChecks = 0;
   mch_channel_handler #(.SENSE_TO_CYCLES(400), .SENSE_TX_CYCLES(200)) mch_channel_handler_i (.*, .evtChannel(),
      .evtPatch(), .patchNum(), .evtSoundOff(), .evtNotesOff(), .evtCtrlReset());
   mch_midi_peer mch_midi_peer_i (.*);
   initial forever #10 clk = ~clk;
   task stopTest;
      if (nMismatch == 0 && totalChecks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task rx(input logic [7:0] m[$]);
      mch_midi_peer_i.send(m);
   endtask
   task chk(input string n, input logic [31:0] e, g);
      totalChecks++;
      if (g !== e) begin
         nMismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Answer is looked at where settled; the request stands until its edge
      for (i = 0; i < 20; i++) begin
         @(negedge clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      se = pslverr;
      if (i >= 20) begin
         nMismatch++;
         stopTest;
      end
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask
   task txexp(input logic [7:0] e[$]);
      int i;
      for (i = 0; mch_midi_peer_i.got.size() < e.size() && i < 500; i++) @(posedge clk);
      chk("tx count", e.size(), mch_midi_peer_i.got.size());
      foreach (e[k]) if (k < mch_midi_peer_i.got.size()) chk("tx byte", e[k], mch_midi_peer_i.got[k]);
      mch_midi_peer_i.got.delete();
   endtask
   task t_regs;
      rdc("ctrl", `MCH_REG_CTRL, `MCH_CTRL_RESET);
      rdc("slidercc", `MCH_REG_SLIDERCC, {25'h0, `MCH_SLIDER_RESET});
      rdc("unmapped", 8'h7C, 32'h0);
      chk("pslverr", 1'b1, se);
   endtask
   task t_prog;
      apb(1'b1, `MCH_REG_INTEN, 32'h1);
      rx('{8'hC5, 8'h2A});
      rdc("patch", `MCH_REG_PATCH, 32'h0000052A);
      chk("irq", 1'b1, irq);
      apb(1'b1, `MCH_REG_INTCLR, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq cleared", 1'b0, irq);
      apb(1'b1, `MCH_REG_INTEN, 32'h0);
      rx('{8'hC0, 8'h7F});
      chk("irq masked", 1'b0, irq);
      rdc("intstat", `MCH_REG_INTSTAT, 32'h1);
      rdc("patch max", `MCH_REG_PATCH, 32'h0000007F);
   endtask
   task t_press;
      rx('{8'hD2, 8'h55, 8'h66});
      apb(1'b1, `MCH_REG_CHSEL, 32'h2);
      apb(1'b0, `MCH_REG_CHSTATE, 32'h0);
      chk("pressure", 7'h66, rd[6:0]);
      rx('{8'hE2, 8'h01, 8'h00});
      rdc("bend low", `MCH_REG_CHBEND, 32'h1);
      rx('{8'hE2, 8'h7F, 8'h7F});
      rdc("bend max", `MCH_REG_CHBEND, 32'h3FFF);
   endtask
   task t_mode;
      rx('{8'hD3, 8'h10, 8'hE3, 8'h00, 8'h00, 8'hB3, 8'h01, 8'h22, 8'h0B, 8'h05, 8'h40, 8'h40});
      chk("hold on", 1'b1, holdOn[3]);
      rx('{8'hB3, 8'h7B, 8'h00});
      chk("release held", 1'b1, evtHoldActive);
      rx('{8'hB3, 8'h40, 8'h3F});
      chk("hold off", 1'b0, holdOn[3]);
      rx('{8'hB3, 8'h7E, 8'h10});
      chk("mono", 1'b1, monoMode[3]);
      rx('{8'hB3, 8'h7F, 8'h00});
      chk("poly", 1'b0, monoMode[3]);
      rx('{8'hB3, 8'h7E, 8'h11});
      chk("mono refused", 1'b0, monoMode[3]);
      rx('{8'hB3, 8'h7C, 8'h00, 8'h7D, 8'h00, 8'h78, 8'h00, 8'h40, 8'h7F, 8'h79, 8'h00});
      apb(1'b1, `MCH_REG_CHSEL, 32'h3);
      rdc("ctl reset", `MCH_REG_CHSTATE, {11'h0, 7'h7F, 14'h0});
      rdc("bend reset", `MCH_REG_CHBEND, 32'h2000);
      chk("hold reset", 1'b0, holdOn[3]);
   endtask
   task t_sense;
      int i;
      rx('{8'hB5, 8'h40, 8'h7F, 8'hFE});
      rdc("monitoring", `MCH_REG_SENSE, 32'h1);
      for (i = 0; evtAllChannels !== 1'b1 && i < 600; i++) @(posedge clk);
      chk("timeout gap", 1'b1, i > 385 && i < 405);
      repeat (2) @(posedge clk);
      chk("hold cleared", 16'h0, holdOn);
      rdc("stopped", `MCH_REG_SENSE, 32'h0);
   endtask
   task t_tx;
      apb(1'b1, `MCH_REG_CTRL, 32'h20);
      stall <= 1'b1;
      pedalPin <= 1'b1;
      // Let a keepalive byte already under way drain before listening
      repeat (10) @(posedge clk);
      mch_midi_peer_i.got.delete();
      repeat (250) @(posedge clk);
      txexp('{});
      apb(1'b1, `MCH_REG_TXCMD, 32'h00000512);
      txexp('{8'h92, 8'h15, 8'h01});
      apb(1'b1, `MCH_REG_TXCMD, 32'h00407F02);
      txexp('{8'h82, 8'h74, 8'h40});
      apb(1'b1, `MCH_REG_TXCMD, 32'h007F1422);
      txexp('{8'hA2, 8'h15, 8'h7F});
      apb(1'b1, `MCH_REG_TXCMD, 32'h00003033);
      txexp('{8'hD3, 8'h30});
      apb(1'b1, `MCH_REG_SLIDERCC, 32'h4A);
      sliderPos <= 7'h33;
      sliderStrobe <= 1'b1;
      @(posedge clk);
      sliderStrobe <= 1'b0;
      txexp('{8'hB2, 8'h4A, 8'h33});
      apb(1'b1, `MCH_REG_CTRL, 32'h22);
      pedalPin <= 1'b0;
      txexp('{8'hB2, 8'h40, 8'h00});
      pedalPin <= 1'b1;
      txexp('{8'hB2, 8'h40, 8'h7F});
      apb(1'b1, `MCH_REG_CTRL, 32'h1);
      repeat (450) @(posedge clk);
      chk("sense count", 1'b1, mch_midi_peer_i.got.size() inside {2, 3});
      foreach (mch_midi_peer_i.got[k]) chk("sense byte", `MCH_BYTE_SENSE, mch_midi_peer_i.got[k]);
      stall <= 1'b0;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_prog;
      t_press;
      t_mode;
      t_sense;
      t_tx;
      stopTest;
   end
endmodule
